/* File: hdl/lsc_map.svh */
// Register offsets, field positions, commands and constants of lsc_top
`ifndef LSC_MAP_SVH
`define LSC_MAP_SVH

// ============================================================
// Register byte offsets
`define LSC_OFF_CTRL     5'h00
`define LSC_OFF_XFER     5'h04
`define LSC_OFF_DATA     5'h08
`define LSC_OFF_STAT     5'h0c

// ============================================================
// Control register fields
`define LSC_CTRL_EN      0
`define LSC_CTRL_MODE_HI 2
`define LSC_CTRL_MODE_LO 1
`define LSC_CTRL_TEST    3
`define LSC_CTRL_RST     4'h0

// ============================================================
// Transfer-control commands, written to bits [1:0]
`define LSC_CMD_CLOSE    2'h0
`define LSC_CMD_OPEN_VOL 2'h1
`define LSC_CMD_OPEN_NV  2'h2
`define LSC_CMD_COPY     2'h3

// Transfer-control read fields
`define LSC_XFER_OPEN    0
`define LSC_XFER_NV      1
`define LSC_XFER_BUSY    2

// ============================================================
// Arithmetic
`define LSC_UNITY        9'h100
`define LSC_MAX8         8'hff
`define LSC_FRAC_BITS    8

`endif

/* File: hdl/lsc_pkg.sv */
// Types shared by the shading correction block
package lsc_pkg;

   // Copy engine states
   typedef enum logic [1:0] {
      LSC_IDLE  = 2'b00,
      LSC_COPY  = 2'b01,
      LSC_DRAIN = 2'b10
   } lsc_copy_t;

   // Output modes; bit 1 set means a 10-bit mode
   typedef enum logic [1:0] {
      LSC_MODE_S8  = 2'b00,
      LSC_MODE_D8  = 2'b01,
      LSC_MODE_S10 = 2'b10,
      LSC_MODE_D10 = 2'b11
   } lsc_mode_t;

endpackage

/* File: hdl/lsc_table_mem.sv */
// Correction table storage, one write port and one registered read port
`timescale 1ns/10ps
`default_nettype none

module lsc_table_mem #(
   parameter int DEPTH = 2048,
   parameter int AW    = 11
) (
   // Clock
   input  wire logic          sys_clk,
   // Write port
   input  wire logic          we,
   input  wire logic [AW-1:0] waddr,
   input  wire logic [7:0]    wdata,
   // Read port
   input  wire logic [AW-1:0] raddr,
   output var  logic [7:0]    rdata
);

   logic [7:0] mem [0:DEPTH-1];

   // Write and registered read
   always_ff @(posedge sys_clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end

endmodule // lsc_table_mem

`default_nettype wire

/* File: hdl/lsc_pix_mult.sv */
// Pixel times (entry + 256) / 256 with saturation to eight bits
`timescale 1ns/10ps
`default_nettype none

`include "lsc_map.svh"

module lsc_pix_mult (
   // Operands
   input  wire logic [7:0] pix,
   input  wire logic [7:0] entry,
   // Result
   output var  logic [7:0] result
);

   logic [8:0]  factor;
   logic [16:0] prod;
   logic [8:0]  scaled;

   // Factor is entry plus one unit, so entry 0 is unity gain
   assign factor = `LSC_UNITY | {1'b0, entry};
   assign prod   = pix * factor;
   assign scaled = prod[16:`LSC_FRAC_BITS];
   // Clamp rather than wrap above full scale
   assign result = scaled[8] ? `LSC_MAX8 : scaled[7:0];

endmodule // lsc_pix_mult

`default_nettype wire

/* File: hdl/lsc_top.sv */
// Line shading correction: register slave, table upload, copy, datapath
//
// The Avalon-MM register port and the register offsets were decided locally.
`timescale 1ns/10ps
`default_nettype none

`include "lsc_map.svh"

module lsc_top #(
   parameter int PIXELS = 2048,
   parameter int AW     = $clog2(PIXELS)
) (
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst,
   // Avalon-MM slave
   input  wire logic [4:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output var  logic [31:0] avs_readdata,
   output var  logic        avs_waitrequest,
   // Pixel stream in
   input  wire logic        pix_valid,
   input  wire logic        pix_first,
   input  wire logic [9:0]  pix_data,
   // Pixel stream out
   output var  logic        out_valid,
   output var  logic        out_first,
   output var  logic [9:0]  out_data
);

   import lsc_pkg::*;

   localparam logic [AW-1:0] LAST = AW'(PIXELS - 1);

   // ============================================================
   // Register state
   logic            corr_en;
   lsc_mode_t       out_mode;
   logic            test_img;
   logic            tbl_open;
   logic            tgt_nv;
   logic [AW:0]     wr_ptr;
   lsc_copy_t       copy_st;
   lsc_copy_t       next_copy_st;
   logic [AW-1:0]   copy_cnt;
   logic [AW-1:0]   copy_addr_d;

   // ============================================================
   // Bus decode
   logic        req;
   logic        wr_fire;
   logic        sel_ctrl;
   logic        sel_xfer;
   logic        sel_data;
   logic        sel_stat;
   logic        ctrl_wr;
   logic        xfer_wr;
   logic        data_wr;
   logic [1:0]  cmd;
   logic        copy_busy;
   logic        ten_bit_wr;
   logic [31:0] rd_mux;

   assign req        = avs_read | avs_write;
   assign wr_fire    = avs_write & ~avs_waitrequest;
   assign sel_ctrl   = avs_address == `LSC_OFF_CTRL;
   assign sel_xfer   = avs_address == `LSC_OFF_XFER;
   assign sel_data   = avs_address == `LSC_OFF_DATA;
   assign sel_stat   = avs_address == `LSC_OFF_STAT;
   assign ctrl_wr    = wr_fire & sel_ctrl & avs_byteenable[0];
   assign xfer_wr    = wr_fire & sel_xfer & avs_byteenable[0];
   assign data_wr    = wr_fire & sel_data & avs_byteenable[0];
   assign cmd        = avs_writedata[1:0];
   assign copy_busy  = copy_st != LSC_IDLE;
   assign ten_bit_wr = avs_writedata[`LSC_CTRL_MODE_HI];

   // Read data selection; unmapped offsets read zero
   assign rd_mux =
      sel_ctrl ? {28'h0000000, test_img, out_mode, corr_en} :
      sel_xfer ? {29'h00000000, copy_busy, tgt_nv, tbl_open} :
      sel_stat ? {16'h0000, 16'(wr_ptr)} : 32'h00000000;

   // Answer one cycle after the request, then raise waitrequest again on the next cycle
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h00000000;
      end else begin
         avs_waitrequest <= ~(req & avs_waitrequest);
         if (req & avs_waitrequest) begin
            avs_readdata <= rd_mux;
         end
      end
   end

   // ============================================================
   // Control register
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         {test_img, out_mode, corr_en} <= `LSC_CTRL_RST;
      end else if (ctrl_wr) begin
         out_mode <= lsc_mode_t'(avs_writedata[`LSC_CTRL_MODE_HI:
                                               `LSC_CTRL_MODE_LO]);
         test_img <= avs_writedata[`LSC_CTRL_TEST];
         // Ten-bit modes cannot carry correction
         corr_en  <= avs_writedata[`LSC_CTRL_EN] & ~ten_bit_wr;
      end
   end

   // ============================================================
   // Upload session and write pointer
   logic open_cmd;
   logic upl_we;

   assign open_cmd = xfer_wr & ~copy_busy &
                     (cmd == `LSC_CMD_OPEN_VOL || cmd == `LSC_CMD_OPEN_NV);
   // Bytes while closed or past the end are dropped
   assign upl_we   = data_wr & tbl_open & ~wr_ptr[AW] &
                     (wr_ptr[AW-1:0] <= LAST);

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         tbl_open <= 1'b0;
         tgt_nv   <= 1'b0;
         wr_ptr   <= '0;
      end else if (open_cmd) begin
         tbl_open <= 1'b1;
         tgt_nv   <= cmd == `LSC_CMD_OPEN_NV;
         wr_ptr   <= '0;
      end else if (xfer_wr & (cmd == `LSC_CMD_CLOSE)) begin
         tbl_open <= 1'b0;
      end else if (upl_we) begin
         wr_ptr   <= wr_ptr + 1'b1;
      end
   end

   // ============================================================
   // Copy engine, stored table into working table
   logic copy_go;
   logic copy_we;

   assign copy_go = xfer_wr & (cmd == `LSC_CMD_COPY) & ~tbl_open;

   always_comb begin
      next_copy_st = copy_st;
      case (copy_st)
         LSC_IDLE:  if (copy_go) next_copy_st = LSC_COPY;
         LSC_COPY:  if (copy_cnt == LAST) next_copy_st = LSC_DRAIN;
         LSC_DRAIN: next_copy_st = LSC_IDLE;
         default:   next_copy_st = LSC_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         copy_st     <= LSC_IDLE;
         copy_cnt    <= '0;
         copy_addr_d <= '0;
         copy_we     <= 1'b0;
      end else begin
         copy_st     <= next_copy_st;
         copy_addr_d <= copy_cnt;
         copy_we     <= copy_st == LSC_COPY;
         if (copy_st == LSC_COPY) begin
            copy_cnt <= copy_cnt + 1'b1;
         end else begin
            copy_cnt <= '0;
         end
      end
   end

   // ============================================================
   // Table memories
   logic          vol_we;
   logic [AW-1:0] vol_waddr;
   logic [7:0]    vol_wdata;
   logic          nv_we;
   logic [7:0]    nv_rdata;
   logic [7:0]    entry;
   logic [AW-1:0] pix_idx;
   logic [AW-1:0] rd_idx;

   // Working table takes uploads of both kinds and copied bytes
   assign vol_we    = upl_we | copy_we;
   assign vol_waddr = copy_we ? copy_addr_d : wr_ptr[AW-1:0];
   assign vol_wdata = copy_we ? nv_rdata : avs_writedata[7:0];
   // Stored table is written only by a non-volatile upload
   assign nv_we     = upl_we & tgt_nv;

   lsc_table_mem #(
      .DEPTH (PIXELS),
      .AW    (AW)
   ) u_vol (
      .sys_clk (sys_clk),
      .we      (vol_we),
      .waddr   (vol_waddr),
      .wdata   (vol_wdata),
      .raddr   (rd_idx),
      .rdata   (entry)
   );

   lsc_table_mem #(
      .DEPTH (PIXELS),
      .AW    (AW)
   ) u_nv (
      .sys_clk (sys_clk),
      .we      (nv_we),
      .waddr   (wr_ptr[AW-1:0]),
      .wdata   (avs_writedata[7:0]),
      .raddr   (copy_cnt),
      .rdata   (nv_rdata)
   );

   // ============================================================
   // Pixel datapath, one entry per sensor pixel
   logic       s1_valid;
   logic       s1_first;
   logic [9:0] s1_pix;
   logic       corr_on;
   logic [7:0] corr_pix;

   assign rd_idx  = pix_first ? '0 : pix_idx;
   assign corr_on = corr_en & ~out_mode[1];

   lsc_pix_mult u_mult (
      .pix    (s1_pix[7:0]),
      .entry  (entry),
      .result (corr_pix)
   );

   // Pixel index follows the line, holding at the last entry
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pix_idx  <= '0;
         s1_valid <= 1'b0;
         s1_first <= 1'b0;
         s1_pix   <= 10'h000;
      end else begin
         s1_valid <= pix_valid;
         s1_first <= pix_valid & pix_first;
         s1_pix   <= pix_data;
         if (pix_valid && rd_idx != LAST) begin
            pix_idx <= rd_idx + 1'b1;
         end else if (pix_valid) begin
            pix_idx <= LAST;
         end
      end
   end

   // Output select: test image, corrected or raw pixel
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         out_valid <= 1'b0;
         out_first <= 1'b0;
         out_data  <= 10'h000;
      end else begin
         out_valid <= s1_valid;
         out_first <= s1_first;
         if (test_img) begin
            out_data <= {2'b00, entry};
         end else if (corr_on) begin
            out_data <= {2'b00, corr_pix};
         end else begin
            out_data <= s1_pix;
         end
      end
   end

   // ============================================================
   // Checks
   sequence s_xfer_read;
      avs_read & sel_xfer & avs_waitrequest;
   endsequence

   sequence s_answer;
      ##1 ~avs_waitrequest;
   endsequence

   property p_read_open;
      @(posedge sys_clk) disable iff (rst)
      s_xfer_read |-> s_answer ##0
         (avs_readdata[`LSC_XFER_OPEN] == $past(tbl_open));
   endproperty
   a_read_open: assert property (p_read_open)
      else $error("open flag misreported");

   property p_closed_ignored;
      @(posedge sys_clk) disable iff (rst)
      (data_wr & ~tbl_open) |=> $stable(wr_ptr);
   endproperty
   a_closed_ignored: assert property (p_closed_ignored)
      else $error("byte taken while closed");

   property p_ptr_step;
      @(posedge sys_clk) disable iff (rst)
      (data_wr & tbl_open & ~open_cmd & (wr_ptr < PIXELS))
         |=> (wr_ptr == $past(wr_ptr) + 1'b1);
   endproperty
   a_ptr_step: assert property (p_ptr_step)
      else $error("write pointer did not advance");

   property p_open_start;
      @(posedge sys_clk) disable iff (rst)
      open_cmd |=> tbl_open && wr_ptr == '0;
   endproperty
   a_open_start: assert property (p_open_start)
      else $error("open did not restart pointer");

   property p_close;
      @(posedge sys_clk) disable iff (rst)
      (xfer_wr & (cmd == `LSC_CMD_CLOSE)) |=> ~tbl_open ##1 ~tbl_open;
   endproperty
   a_close: assert property (p_close)
      else $error("close left table open");

   property p_ten_bit_off;
      @(posedge sys_clk) disable iff (rst)
      out_mode[1] |-> ~corr_en;
   endproperty
   a_ten_bit_off: assert property (p_ten_bit_off)
      else $error("correction on in 10-bit mode");

   property p_nv_only_nv;
      @(posedge sys_clk) disable iff (rst)
      nv_we |-> tgt_nv && tbl_open && !copy_busy;
   endproperty
   a_nv_only_nv: assert property (p_nv_only_nv)
      else $error("stored table written outside nv upload");

   property p_raw_pass;
      @(posedge sys_clk) disable iff (rst)
      (s1_valid & ~test_img & ~corr_on) |=> out_data == $past(s1_pix);
   endproperty
   a_raw_pass: assert property (p_raw_pass)
      else $error("pixel altered with correction off");

   property p_corr_bound;
      @(posedge sys_clk) disable iff (rst)
      (s1_valid & ~test_img & corr_on)
         |=> out_data[9:8] == 2'b00 && out_data[7:0] >= $past(s1_pix[7:0]);
   endproperty
   a_corr_bound: assert property (p_corr_bound)
      else $error("corrected pixel below input or wrapped");

   property p_copy_end;
      @(posedge sys_clk) disable iff (rst)
      (copy_st == LSC_COPY && copy_cnt == LAST)
         |=> copy_st == LSC_DRAIN ##1 copy_st == LSC_IDLE;
   endproperty
   a_copy_end: assert property (p_copy_end)
      else $error("copy did not finish after last entry");

endmodule // lsc_top

`default_nettype wire

/* File: verification/lsc_line_src.sv */
// Pixel line source standing in for the sensor side of the stream
`timescale 1ns/10ps
`default_nettype none

module lsc_line_src #(
   parameter int LEN = 67
) (
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rst,
   // Line request
   input  wire logic       go,
   input  wire logic       slow,
   input  wire logic [9:0] base,
   input  wire logic [9:0] step,
   // Pixel stream
   output var  logic       pix_valid,
   output var  logic       pix_first,
   output var  logic [9:0] pix_data,
   output var  logic       busy
);
   int   idx;
   logic gap;

   // ============================================================
   // One ramp line, a pixel every cycle or every other cycle
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         busy      <= 1'b0;
         idx       <= 0;
         gap       <= 1'b0;
         pix_valid <= 1'b0;
         pix_first <= 1'b0;
         pix_data  <= 10'h000;
      end else if (busy && !(slow && gap) && idx < LEN) begin
         pix_valid <= 1'b1;
         pix_first <= (idx == 0);
         pix_data  <= base + step * 10'(idx);
         idx       <= idx + 1;
         gap       <= 1'b1;
      end else begin
         // Idle lines keep moving so stale data never looks valid
         pix_valid <= 1'b0;
         pix_first <= ~pix_first;
         pix_data  <= ~pix_data;
         gap       <= 1'b0;
         if (go && !busy) begin
            busy <= 1'b1;
            idx  <= 0;
         end else if (idx >= LEN) begin
            busy <= 1'b0;
         end
      end
   end
endmodule // lsc_line_src

`default_nettype wire

/* File: verification/line_shading_correction_test.sv */
// Self-checking bench for the shading correction block
`timescale 1ns/10ps
`default_nettype none

`include "lsc_map.svh"

module line_shading_correction_test;
   import lsc_pkg::*;

   localparam int P = 64;
   // Clock, reset and bus
   logic        sys_clk        = 1'b0;
   logic        rst            = 1'b1;
   logic [4:0]  avs_address    = 5'h00;
   logic        avs_read       = 1'b0;
   logic        avs_write      = 1'b0;
   logic [31:0] avs_writedata  = 32'h0;
   logic [3:0]  avs_byteenable = 4'hf;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   // Stream and source control
   logic        pix_valid, pix_first, out_valid, out_first, busy;
   logic [9:0]  pix_data, out_data;
   logic        go   = 1'b0;
   logic        slow = 1'b0;
   logic [9:0]  base = 10'h000;
   logic [9:0]  step = 10'h001;
   // Reference model state
   logic [7:0]  vol [P];
   logic [7:0]  nv [P];
   logic        en, tst;
   logic [1:0]  mode;
   logic [10:0] expq [$];
   int          idx;
   int          num_errors = 0;
   int          checked = 0;

   always #5 sys_clk = ~sys_clk;

   lsc_top #(.PIXELS(P)) dut (
      .sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .pix_valid(pix_valid), .pix_first(pix_first), .pix_data(pix_data),
      .out_valid(out_valid), .out_first(out_first), .out_data(out_data));

   lsc_line_src #(.LEN(P + 3)) src (
      .sys_clk(sys_clk), .rst(rst), .go(go), .slow(slow), .base(base),
      .step(step), .pix_valid(pix_valid), .pix_first(pix_first),
      .pix_data(pix_data), .busy(busy));

   // ============================================================
   // Reporting
   task automatic end_of_test;
      $display("errors %0d, comparisons %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic fail(input string msg);
      num_errors++;
      $display("[ERR] %0t %s", $time, msg);
   endtask

   task automatic chk32(input logic [31:0] got, exp, mask, input string m);
      checked++;
      if ((got & mask) !== (exp & mask)) fail(m);
   endtask

   task automatic chk_pix(input logic [10:0] got, exp);
      checked++;
      if (got !== exp) fail("pixel output differs");
   endtask

   // ============================================================
   // Host calibration entry: brightest*256/average - 256, rounded
   function automatic logic [7:0] cal_entry(input int lit, input int avg);
      return 8'((lit * 256 + avg / 2) / avg - 256);
   endfunction

   // Expected pixel from the model table and settings
   function automatic logic [9:0] exp_pix(input logic [9:0] p, input int i);
      logic [7:0]  v;
      logic [16:0] m;
      v = vol[(i >= P) ? P - 1 : i];
      m = 17'(p[7:0]) * (17'(v) + 17'h100);
      if (tst) return {2'b00, v};
      if (en && !mode[1]) return (m[16]) ? 10'h0ff : {2'b00, m[15:8]};
      return p;
   endfunction

   // Scoreboard: inputs queued, outputs compared in order
   always @(posedge sys_clk) begin
      if (pix_valid === 1'b1) begin
         idx = (pix_first === 1'b1) ? 0 : idx + 1;
         expq.push_back({pix_first, exp_pix(pix_data, idx)});
      end
      if (out_valid === 1'b1) begin
         if (expq.size() == 0) fail("output without input");
         else chk_pix({out_first, out_data}, expq.pop_front());
      end
   end

   // ============================================================
   // Bus master: hold until waitrequest low, then one idle cycle
   task automatic bus(input logic rd, input logic [4:0] a,
                      input logic [31:0] d, input logic [3:0] be,
                      output logic [31:0] q);
      int n;
      avs_address    <= a;
      avs_writedata  <= d;
      avs_byteenable <= be;
      avs_read       <= rd;
      avs_write      <= !rd;
      for (n = 0; n < 16; n++) begin
         @(posedge sys_clk);
         if (avs_waitrequest === 1'b0) break;
      end
      q = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
      if (n == 16) begin
         fail("bus timeout");
         end_of_test;
      end
      @(posedge sys_clk);
   endtask

   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b0, a, d, 4'hf, q);
   endtask

   task automatic rd(input logic [4:0] a, output logic [31:0] q);
      bus(1'b1, a, 32'h0, 4'hf, q);
   endtask

   // Control setting; a 10-bit mode drops the enable
   task automatic set_ctrl(input logic e, input logic [1:0] m, input logic t);
      logic [31:0] q;
      wr(`LSC_OFF_CTRL, {28'h0, t, m, e});
      en   = e && !m[1];
      mode = m;
      tst  = t;
      rd(`LSC_OFF_CTRL, q);
      chk32(q, {28'h0, t, m, en}, 32'hf, "control readback");
   endtask

   // Table upload session with corner entries 0 and 255
   task automatic upload(input logic [1:0] cmd, input int n);
      logic [31:0] q;
      logic [7:0]  b;
      wr(`LSC_OFF_XFER, {30'h0, cmd});
      rd(`LSC_OFF_XFER, q);
      chk32(q, {30'h0, cmd[1], 1'b1}, 32'h3, "open state");
      for (int i = 0; i < n; i++) begin
         // Entry 0 is unity gain and entry 1 the largest gain; entry 2 is a calibrated value
         b = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
         if (i == 2) b = cal_entry(170, 160);
         wr(`LSC_OFF_DATA, {24'h0, b});
         if (i < P) vol[i] = b;
         if (i < P && cmd == `LSC_CMD_OPEN_NV) nv[i] = b;
         if (i == 57) begin
            bus(1'b0, `LSC_OFF_DATA, 32'h0000_00a5, 4'he, q);
            rd(`LSC_OFF_STAT, q);
            chk32(q, 32'd58, 32'hffff, "pointer after packet");
         end
      end
      rd(`LSC_OFF_STAT, q);
      chk32(q, 32'(P), 32'hffff, "pointer at end");
      wr(`LSC_OFF_XFER, {30'h0, `LSC_CMD_CLOSE});
      rd(`LSC_OFF_XFER, q);
      chk32(q, 32'h0, 32'h1, "closed state");
   endtask

   // One random ramp line through the datapath
   task automatic line(input logic s);
      int n;
      slow <= s;
      base <= 10'($urandom);
      step <= 10'($urandom_range(1, 40));
      go   <= 1'b1;
      @(posedge sys_clk);
      go <= 1'b0;
      for (n = 0; n < 400; n++) begin
         @(posedge sys_clk);
         if (busy === 1'b0) break;
      end
      if (n == 400) begin
         fail("line timeout");
         end_of_test;
      end
      repeat (4) @(posedge sys_clk);
   endtask

   // ============================================================
   // Main sequence
   initial begin
      logic [31:0] q;
      int          n;
      void'($urandom(32'h987b));
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      rd(`LSC_OFF_CTRL, q);
      chk32(q, 32'h0, 32'hf, "control after reset");
      rd(`LSC_OFF_XFER, q);
      chk32(q, 32'h0, 32'h7, "transfer after reset");
      wr(`LSC_OFF_DATA, 32'h0000_005a);
      rd(`LSC_OFF_STAT, q);
      chk32(q, 32'h0, 32'hffff, "byte taken while closed");
      wr(5'h10, 32'hffff_ffff);
      rd(5'h10, q);
      chk32(q, 32'h0, 32'hffff_ffff, "unmapped read");
      upload(`LSC_CMD_OPEN_NV, P + 2);
      chk32(32'(cal_entry(170, 165)), 32'd8, 32'hff, "cal entry");
      set_ctrl(1'b0, LSC_MODE_S8, 1'b0);
      line(1'b0);
      for (int m = 0; m < 4; m++) begin
         set_ctrl(1'b1, 2'(m), 1'b0);
         line(m[0]);
      end
      set_ctrl(1'b0, LSC_MODE_S8, 1'b1);
      line(1'b1);
      upload(`LSC_CMD_OPEN_VOL, P);
      line(1'b0);
      wr(`LSC_OFF_XFER, {30'h0, `LSC_CMD_COPY});
      for (n = 0; n < 60; n++) begin
         rd(`LSC_OFF_XFER, q);
         if (q[`LSC_XFER_BUSY] === 1'b0) break;
      end
      if (n == 60) fail("copy never finished");
      vol = nv;
      line(1'b0);
      set_ctrl(1'b1, LSC_MODE_D8, 1'b0);
      line(1'b1);
      chk32(32'(expq.size()), 32'h0, 32'hffff_ffff, "pixels lost");
      end_of_test;
   end
endmodule // line_shading_correction_test

`default_nettype wire
